/* File: rtl/nand_host_ctrl.sv */
`timescale 1ns/10ps
// ------------------------------------------------------------
// How it works
// - Command byte driven on low lanes with command latch high, taken on strobe rise.
// - Address cycles use address latch high; data cycles keep both latches low.
// - Commands and addresses use low lanes only; high lanes held low then.
// - Four address cycles for read and program: column, row low, row mid, two top bits; erase sends three, ID one.
// - Program is 80h, address, data, then 10h.
// - Erase is 60h, block address, then D0h.
// - Host must not program a page more than three times between erases; the controller does not count or enforce this.
// - While busy only status read and reset may be sent.
// - After 80h only 10h or FFh may follow.
// - Read strobes start only after all address cycles.
// ------------------------------------------------------------
module nand_host_ctrl #(
   parameter int WORDS_MAX = 264,
   parameter int CW = 6
) (
   // Clock and reset
   input wire logic CLK_SYS,
   input wire logic RST_N,
   // User request
   input wire logic REQ_VALID,
   input wire nand_host_pkg::op_t REQ_OP,
   input wire logic [7:0] REQ_COL,
   input wire logic [17:0] REQ_ROW,
   input wire logic [8:0] REQ_WORDS,
   output logic REQ_READY,
   // User write data
   input wire logic [15:0] WR_DATA,
   output logic WR_TAKE,
   // User read data and completion
   output logic [15:0] RD_DATA,
   output logic RD_VALID,
   output logic DONE,
   output logic REFUSED,
   // Flash pins
   output logic CLE,
   output logic ALE,
   output logic CE_N,
   output logic WE_N,
   output logic RE_N,
   output logic WP_N,
   output logic [15:0] IO_OUT,
   output logic IO_OE,
   input wire logic [15:0] IO_IN,
   input wire logic READY_BUSY_N
);
   typedef enum logic [3:0] {
      S_IDLE, S_CMD1, S_ADDR, S_DATA, S_CMD2, S_WB, S_WAIT, S_TURN, S_READ, S_FIN
   } state_t;

   state_t st_q;
   nand_host_pkg::op_t op_q;
   logic [7:0] col_q;
   logic [17:0] row_q;
   logic [8:0] left_q;
   logic [2:0] acyc_q;
   logic [7:0] wait_q;
   logic busy_seen_q;
   logic tmr_start_q;
   logic tmr_low;
   logic tmr_done;

   // ------------------------------------------------------------
   // Decoding
   // ------------------------------------------------------------
   wire op_prog = (op_q == nand_host_pkg::OP_PROGRAM);
   wire op_erase = (op_q == nand_host_pkg::OP_ERASE);
   wire op_rd = (op_q == nand_host_pkg::OP_READ) || (op_q == nand_host_pkg::OP_READ_SPARE);
   // Program sends no 00h first: after a spare read, run a main read before programming main words
   wire [7:0] first_cmd =
      (op_q == nand_host_pkg::OP_READ) ? nand_host_pkg::CMD_READ_MAIN :
      (op_q == nand_host_pkg::OP_READ_SPARE) ? nand_host_pkg::CMD_READ_SPARE :
      op_prog ? nand_host_pkg::CMD_SERIAL_IN :
      op_erase ? nand_host_pkg::CMD_ERASE_SETUP :
      (op_q == nand_host_pkg::OP_STATUS) ? nand_host_pkg::CMD_STATUS :
      (op_q == nand_host_pkg::OP_ID) ? nand_host_pkg::CMD_ID_MAIN :
      (op_q == nand_host_pkg::OP_ID_EXT) ? nand_host_pkg::CMD_ID_EXT : nand_host_pkg::CMD_RESET;
   // Program confirm follows 80h directly so no stray command can cancel it
   wire [7:0] second_cmd = op_erase ? nand_host_pkg::CMD_ERASE_GO : nand_host_pkg::CMD_PROG_EXEC;
   // Erase sends row only (three cycles); column cycle skipped, column bit A8 never sent
   wire [2:0] acyc_last = 3'(nand_host_pkg::ADDR_CYCLES - 1);
   wire [7:0] addr_byte =
      (acyc_q == 3'h0) ? col_q :
      (acyc_q == 3'h1) ? row_q[7:0] :
      (acyc_q == 3'h2) ? row_q[15:8] : {6'h00, row_q[17:16]};
   wire needs_addr = op_rd || op_prog || op_erase || (op_q == nand_host_pkg::OP_ID) ||
      (op_q == nand_host_pkg::OP_ID_EXT);
   wire id_op = (op_q == nand_host_pkg::OP_ID) || (op_q == nand_host_pkg::OP_ID_EXT);
   wire status_op = (op_q == nand_host_pkg::OP_STATUS);
   // While busy only status and reset are legal requests
   wire allowed = (REQ_OP == nand_host_pkg::OP_STATUS) || (REQ_OP == nand_host_pkg::OP_RESET) ||
      READY_BUSY_N;
   wire lanes_cmd = (st_q == S_CMD1) || (st_q == S_CMD2) || (st_q == S_ADDR);
   wire [15:0] drive_word = lanes_cmd ? {8'h00, ((st_q == S_ADDR) ? addr_byte :
      (st_q == S_CMD1) ? first_cmd : second_cmd)} : WR_DATA;
   wire [CW-1:0] low_len = CW'(nand_host_pkg::WP_CYC > nand_host_pkg::RP_CYC ?
      nand_host_pkg::WP_CYC : nand_host_pkg::RP_CYC);
   wire [CW-1:0] high_len = CW'(nand_host_pkg::WH_CYC);
   wire in_write = lanes_cmd || (st_q == S_DATA);
   // The die drives the word only while the strobe is low, so take it before the strobe rises
   wire rd_sample = (st_q == S_READ) && !tmr_low && !RE_N;

   nand_strobe_timer #(.CW(CW)) nand_strobe_timer_i (
      .clk(CLK_SYS),
      .rst_n(RST_N),
      .start(tmr_start_q),
      .low_cycles(low_len),
      .high_cycles(high_len),
      .strobe_low(tmr_low),
      .done(tmr_done)
   );

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
      begin
         st_q <= S_IDLE;
         op_q <= nand_host_pkg::OP_RESET;
         col_q <= 8'h00;
         row_q <= '0;
         left_q <= '0;
         acyc_q <= 3'h0;
         wait_q <= 8'h00;
         busy_seen_q <= 1'b0;
         tmr_start_q <= 1'b0;
         REQ_READY <= 1'b0;
         WR_TAKE <= 1'b0;
         RD_DATA <= 16'h0000;
         RD_VALID <= 1'b0;
         DONE <= 1'b0;
         REFUSED <= 1'b0;
         CLE <= 1'b0;
         ALE <= 1'b0;
         CE_N <= 1'b1;
         WE_N <= 1'b1;
         RE_N <= 1'b1;
         WP_N <= 1'b0;
         IO_OUT <= 16'h0000;
         IO_OE <= 1'b0;
      end
      else
      begin
         tmr_start_q <= 1'b0;
         WR_TAKE <= 1'b0;
         RD_VALID <= 1'b0;
         DONE <= 1'b0;
         REFUSED <= 1'b0;
         WE_N <= !(in_write && tmr_low);
         RE_N <= !((st_q == S_READ) && tmr_low);
         IO_OUT <= drive_word;
         IO_OE <= in_write;
         unique case (st_q)
            S_IDLE:
            begin
               REQ_READY <= 1'b1;
               CLE <= 1'b0;
               ALE <= 1'b0;
               if (REQ_VALID && REQ_READY)
               begin
                  REQ_READY <= 1'b0;
                  if (!allowed)
                     REFUSED <= 1'b1;
                  else
                  begin
                     op_q <= REQ_OP;
                     col_q <= REQ_COL;
                     // Any block is accepted; bad-block tracking stays with the user
                     row_q <= REQ_ROW;
                     left_q <= (REQ_WORDS > 9'(WORDS_MAX)) ? 9'(WORDS_MAX) : REQ_WORDS;
                     // Erase skips the column cycle: it addresses a whole block
                     acyc_q <= (REQ_OP == nand_host_pkg::OP_ERASE) ? 3'h1 : 3'h0;
                     CE_N <= 1'b0;
                     // Regulator enabled only for program and erase
                     WP_N <= (REQ_OP == nand_host_pkg::OP_PROGRAM) || (REQ_OP == nand_host_pkg::OP_ERASE);
                     CLE <= 1'b1;
                     st_q <= S_CMD1;
                     tmr_start_q <= 1'b1;
                  end
               end
            end
            S_CMD1:
               if (tmr_done)
               begin
                  CLE <= 1'b0;
                  if (needs_addr)
                  begin
                     ALE <= 1'b1;
                     st_q <= S_ADDR;
                     if (id_op)
                        acyc_q <= acyc_last;
                     tmr_start_q <= 1'b1;
                  end
                  else if (status_op)
                  begin
                     wait_q <= 8'(nand_host_pkg::WHR_CYC);
                     left_q <= 9'h001;
                     st_q <= S_TURN;
                  end
                  else
                  begin
                     wait_q <= 8'(nand_host_pkg::WB_CYC);
                     busy_seen_q <= 1'b0;
                     st_q <= S_WB;
                  end
               end
            S_ADDR:
               if (tmr_done)
               begin
                  if (acyc_q == acyc_last)
                  begin
                     ALE <= 1'b0;
                     if (op_prog)
                     begin
                        st_q <= S_DATA;
                        WR_TAKE <= 1'b1;
                        tmr_start_q <= 1'b1;
                     end
                     else if (op_erase)
                     begin
                        st_q <= S_CMD2;
                        tmr_start_q <= 1'b1;
                     end
                     else if (id_op)
                     begin
                        wait_q <= 8'(nand_host_pkg::WHR_CYC);
                        left_q <= (op_q == nand_host_pkg::OP_ID) ? 9'h002 : 9'h001;
                        st_q <= S_TURN;
                     end
                     else
                     begin
                        wait_q <= 8'(nand_host_pkg::WB_CYC);
                        busy_seen_q <= 1'b0;
                        st_q <= S_WB;
                     end
                  end
                  else
                  begin
                     acyc_q <= acyc_q + 3'h1;
                     tmr_start_q <= 1'b1;
                  end
               end
            S_DATA:
               if (tmr_done)
               begin
                  if (left_q <= 9'h001)
                  begin
                     st_q <= S_CMD2;
                     tmr_start_q <= 1'b1;
                  end
                  else
                  begin
                     left_q <= left_q - 9'h001;
                     WR_TAKE <= 1'b1;
                     tmr_start_q <= 1'b1;
                  end
               end
            S_CMD2:
               if (tmr_done)
               begin
                  CLE <= 1'b0;
                  wait_q <= 8'(nand_host_pkg::WB_CYC);
                  busy_seen_q <= 1'b0;
                  st_q <= S_WB;
               end
               else
                  // Raised a cycle after entry, once the lanes no longer carry a data word
                  CLE <= 1'b1;
            S_WB:
            begin
               if (!READY_BUSY_N)
                  busy_seen_q <= 1'b1;
               if (wait_q != 8'h00)
                  wait_q <= wait_q - 8'h01;
               else
                  st_q <= S_WAIT;
            end
            S_WAIT:
               if (READY_BUSY_N)
               begin
                  if (op_rd && left_q != 9'h000)
                  begin
                     wait_q <= 8'(nand_host_pkg::REH_CYC);
                     st_q <= S_TURN;
                  end
                  else
                     st_q <= S_FIN;
               end
            S_TURN:
               if (wait_q != 8'h00)
                  wait_q <= wait_q - 8'h01;
               else
               begin
                  st_q <= S_READ;
                  tmr_start_q <= 1'b1;
               end
            S_READ:
            begin
               // Sampled at the end of the low phase; one capture per strobe
               if (rd_sample)
               begin
                  RD_VALID <= 1'b1;
                  RD_DATA <= IO_IN;
               end
               if (tmr_done)
               begin
                  left_q <= left_q - 9'h001;
                  if (left_q == 9'h001)
                     st_q <= S_FIN;
                  else
                     tmr_start_q <= 1'b1;
               end
            end
            S_FIN:
            begin
               DONE <= 1'b1;
               CE_N <= 1'b1;
               WP_N <= 1'b0;
               st_q <= S_IDLE;
            end
            default:
               st_q <= S_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   lanes_low_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      (IO_OE && (CLE || ALE)) |-> (IO_OUT[15:8] == 8'h00))
      else $error("high lanes driven during command or address");
   wp_guard_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      WP_N |-> (op_prog || op_erase))
      else $error("write protect released for a non-modifying operation");
   latch_excl_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      !(CLE && ALE))
      else $error("both latch enables high");
   busy_wait_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      (st_q == S_WAIT && !READY_BUSY_N) |=> (st_q == S_WAIT))
      else $error("left wait while device busy");
   no_read_addr_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      ALE |-> RE_N)
      else $error("read strobe during address cycles");
   refuse_busy_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      (st_q == S_IDLE && REQ_VALID && REQ_READY && !READY_BUSY_N &&
       REQ_OP != nand_host_pkg::OP_STATUS && REQ_OP != nand_host_pkg::OP_RESET) |=> REFUSED)
      else $error("busy request not refused");
   ce_hold_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      (st_q == S_WAIT) |-> !CE_N)
      else $error("chip enable dropped during operation");
   done_pulse_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      DONE |=> !DONE ##0 CE_N)
      else $error("done not a single pulse");
endmodule

/* File: rtl/nand_host_pkg.sv */
package nand_host_pkg;
   // ------------------------------------------------------------
   // Command codes
   // ------------------------------------------------------------
   localparam logic [7:0] CMD_READ_MAIN = 8'h00;
   localparam logic [7:0] CMD_READ_SPARE = 8'h50;
   localparam logic [7:0] CMD_SERIAL_IN = 8'h80;
   localparam logic [7:0] CMD_PROG_EXEC = 8'h10;
   localparam logic [7:0] CMD_ERASE_SETUP = 8'h60;
   localparam logic [7:0] CMD_ERASE_GO = 8'hD0;
   localparam logic [7:0] CMD_STATUS = 8'h70;
   localparam logic [7:0] CMD_ID_MAIN = 8'h90;
   localparam logic [7:0] CMD_ID_EXT = 8'h91;
   localparam logic [7:0] CMD_RESET = 8'hFF;

   // ------------------------------------------------------------
   // Status byte fields and extended ID
   // ------------------------------------------------------------
   localparam int ST_FAIL_BIT = 0;
   localparam int ST_READY_BIT = 6;
   localparam int ST_UNPROT_BIT = 7;
   localparam logic [7:0] EXT_ID_FOUR_BLOCK = 8'h20;

   // ------------------------------------------------------------
   // Geometry
   // ------------------------------------------------------------
   localparam int PAGE_WORDS = 264;
   localparam int MAIN_WORDS = 256;
   localparam int SPARE_WORDS = 8;
   localparam int PAGES_PER_BLOCK = 32;
   localparam int BLOCKS = 8192;
   localparam int MIN_VALID_BLOCKS = 8032;
   localparam int MAX_PROGRAMS_PER_PAGE = 3;
   localparam int ADDR_CYCLES = 4;
   localparam int ROW_BITS = 18;
   localparam int HIGH_ADDR_BITS = 2;

   // ------------------------------------------------------------
   // Bus timing, in ns, and derived cycles at 125 MHz
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 8;
   localparam int T_WP_NS = 25;
   localparam int T_WH_NS = 25;
   localparam int T_RP_NS = 35;
   localparam int T_REH_NS = 15;
   localparam int T_WHR_NS = 30;
   localparam int T_WB_NS = 200;
   localparam int WP_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WH_CYC = (T_WH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RP_CYC = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int REH_CYC = (T_REH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WHR_CYC = (T_WHR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WB_CYC = (T_WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ------------------------------------------------------------
   // User operations
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      OP_READ = 3'h0,
      OP_READ_SPARE = 3'h1,
      OP_PROGRAM = 3'h2,
      OP_ERASE = 3'h3,
      OP_STATUS = 3'h4,
      OP_ID = 3'h5,
      OP_ID_EXT = 3'h6,
      OP_RESET = 3'h7
   } op_t;
endpackage

/* File: rtl/nand_strobe_timer.sv */
`timescale 1ns/10ps
// Strobe pulse generator: low phase then high phase, each of a set length
module nand_strobe_timer #(
   parameter int CW = 6
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Control
   input wire logic start,
   input wire logic [CW-1:0] low_cycles,
   input wire logic [CW-1:0] high_cycles,
   // Status
   output logic strobe_low,
   output logic done
);
   logic [CW-1:0] cnt_q;
   logic [1:0] ph_q;
   wire in_low = (ph_q == 2'h1);
   wire in_high = (ph_q == 2'h2);
   wire cnt_end = (cnt_q == {{(CW-1){1'b0}}, 1'b1});

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_q <= '0;
         ph_q <= 2'h0;
         strobe_low <= 1'b0;
         done <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         if (ph_q == 2'h0 && start)
         begin
            ph_q <= 2'h1;
            cnt_q <= low_cycles;
            strobe_low <= 1'b1;
         end
         else if (in_low && cnt_end)
         begin
            ph_q <= 2'h2;
            cnt_q <= high_cycles;
            strobe_low <= 1'b0;
         end
         else if (in_high && cnt_end)
         begin
            ph_q <= 2'h0;
            done <= 1'b1;
         end
         else if (in_low || in_high)
            cnt_q <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
      end
   end

   strobe_low_a: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(strobe_low) |-> strobe_low [*2])
      else $error("strobe low phase too short");
endmodule

/* File: testbench/nand_flash_model.sv */
`timescale 1ns/10ps
// Behavioural flash die; no bad blocks, erased words read FFFF
module nand_flash_model #(
   parameter logic [7:0] MAKER_ID = 8'h5A, // Arbitrary value
   parameter logic [7:0] DEVICE_ID = 8'hC3 // Arbitrary value
) (
   // Latch and strobe pins
   input wire logic cle,
   input wire logic ale,
   input wire logic ce_n,
   input wire logic we_n,
   input wire logic re_n,
   input wire logic wp_n,
   // Data lanes and status
   input wire logic [15:0] io_out,
   output logic [15:0] io_in,
   output logic ready_busy_n
);
   logic [15:0] mem [int];
   logic [15:0] pend [int];
   logic [7:0] cmd_q = 8'h00;
   logic [17:0] row_q = 18'h00000;
   logic [8:0] col_q = 9'h000;
   logic [15:0] dout = 16'h0000;
   logic half_q = 1'b0;
   logic fail_q = 1'b0;
   logic rb_q = 1'b1;
   int acnt = 0;
   int ptr = 0;
   int idx;
   // Released lane shows the inverse so a stale value never passes
   assign io_in = (!ce_n && !re_n) ? dout : ~dout;
   assign ready_busy_n = rb_q;
   function automatic int key(input logic [17:0] r, input int c);
      return r * 512 + c;
   endfunction
   task automatic go_busy(input int ns);
      rb_q = 1'b0;
      rb_q <= #(ns) 1'b1;
   endtask
   // ------------------------------------------------------------
   // Write strobe: command, address, data
   // ------------------------------------------------------------
   // Chip enable only gates new input; busy work runs on regardless
   always @(posedge we_n) if (!ce_n)
   begin
      if (cle)
      begin
         cmd_q = io_out[7:0];
         acnt = 0;
         ptr = 0;
         case (io_out[7:0])
            8'h00: half_q = 1'b0;
            8'h50: half_q = 1'b1;
            8'h80: pend.delete();
            8'h10: if (wp_n)
            begin
               foreach (pend[k]) mem[k] = (mem.exists(k) ? mem[k] : 16'hFFFF) & pend[k];
               fail_q = 1'b0;
               go_busy(800);
            end
            else fail_q = 1'b1;
            8'hD0: if (wp_n)
            begin
               for (int p = 0; p < 32; p++)
                  for (int c = 0; c < 264; c++) mem.delete(key({row_q[17:5], 5'h00} + p, c));
               fail_q = 1'b0;
               go_busy(1200);
            end
            else fail_q = 1'b1;
            8'hFF:
            begin
               pend.delete();
               go_busy(160);
            end
            default: ;
         endcase
      end
      else if (ale)
      begin
         idx = acnt + ((cmd_q == 8'h60) ? 1 : 0);
         case (idx)
            0: col_q = half_q ? 9'(256 + io_out[2:0]) : {1'b0, io_out[7:0]};
            1: row_q[7:0] = io_out[7:0];
            2: row_q[15:8] = io_out[7:0];
            default: row_q[17:16] = io_out[1:0];
         endcase
         acnt++;
         ptr = col_q;
         if ((cmd_q == 8'h00 || cmd_q == 8'h50) && acnt == 4) go_busy(400);
      end
      else
      begin
         pend[key(row_q, ptr)] = io_out;
         ptr++;
      end
   end
   // ------------------------------------------------------------
   // Read strobe: each fall presents the next word
   // ------------------------------------------------------------
   always @(negedge re_n) if (!ce_n)
   begin
      case (cmd_q)
         8'h70: dout = {8'h00, wp_n, rb_q, 5'h00, fail_q};
         8'h90: dout = {8'h00, (ptr == 0) ? MAKER_ID : DEVICE_ID};
         8'h91: dout = 16'h0020;
         default: dout = mem.exists(key(row_q, ptr)) ? mem[key(row_q, ptr)] : 16'hFFFF;
      endcase
      ptr++;
   end
endmodule

/* File: testbench/nand_host_ctrl_tb.sv */
`timescale 1ns/10ps
module nand_host_ctrl_tb;
   localparam logic [7:0] MAKER = 8'h5A; // Arbitrary value
   localparam logic [7:0] DEVICE = 8'hC3; // Arbitrary value
   logic CLK_SYS, RST_N, REQ_VALID, REQ_READY, WR_TAKE, RD_VALID, DONE, REFUSED;
   logic CLE, ALE, CE_N, WE_N, RE_N, WP_N, IO_OE, READY_BUSY_N;
   logic rb_die, ext_busy_n, exp_ref, got_ref, take_seen;
   nand_host_pkg::op_t REQ_OP;
   logic [7:0] REQ_COL;
   logic [17:0] REQ_ROW;
   logic [8:0] REQ_WORDS;
   logic [15:0] WR_DATA, RD_DATA, IO_OUT, IO_IN;
   logic [15:0] wdata [0:7];
   logic [15:0] rq [$];
   int wi, cyc, miscompares, cmp_count;
   logic got_done;
   assign WR_DATA = wdata[wi];
   // A second die on the shared open-drain ready line can hold it low
   assign READY_BUSY_N = rb_die & ext_busy_n;
   nand_host_ctrl nand_host_ctrl_i (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .REQ_VALID(REQ_VALID), .REQ_OP(REQ_OP),
      .REQ_COL(REQ_COL), .REQ_ROW(REQ_ROW), .REQ_WORDS(REQ_WORDS), .REQ_READY(REQ_READY), .WR_DATA(WR_DATA),
      .WR_TAKE(WR_TAKE), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID), .DONE(DONE), .REFUSED(REFUSED), .CLE(CLE),
      .ALE(ALE), .CE_N(CE_N), .WE_N(WE_N), .RE_N(RE_N), .WP_N(WP_N), .IO_OUT(IO_OUT), .IO_OE(IO_OE),
      .IO_IN(IO_IN), .READY_BUSY_N(READY_BUSY_N));
   nand_flash_model #(.MAKER_ID(MAKER), .DEVICE_ID(DEVICE)) nand_flash_model_i (.cle(CLE), .ale(ALE),
      .ce_n(CE_N), .we_n(WE_N), .re_n(RE_N), .wp_n(WP_N), .io_out(IO_OUT), .io_in(IO_IN),
      .ready_busy_n(rb_die));
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic finish_test;
      $display("Compares %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // Hold the request until a negedge shows ready, so the next rising edge takes it
   task automatic run_op(input nand_host_pkg::op_t op, input logic [7:0] col, input logic [17:0] row,
         input logic [8:0] n);
      int t;
      @(negedge CLK_SYS);
      wi = 0;
      take_seen = 1'b0;
      REQ_VALID = 1'b1;
      REQ_OP = op;
      REQ_COL = col;
      REQ_ROW = row;
      REQ_WORDS = n;
      while (REQ_READY !== 1'b1) @(negedge CLK_SYS);
      @(negedge CLK_SYS);
      REQ_VALID = 1'b0;
      rq.delete();
      got_done = 1'b0;
      got_ref = 1'b0;
      // Pulses stand from one rising edge to the next, so look mid-cycle, the take cycle included
      for (t = 0; t < 20000 && !got_done && !got_ref; t++)
      begin
         if (RD_VALID === 1'b1) rq.push_back(RD_DATA);
         if (DONE === 1'b1) got_done = 1'b1;
         if (REFUSED === 1'b1) got_ref = 1'b1;
         if (!got_done && !got_ref) @(negedge CLK_SYS);
      end
      check({14'h0000, got_ref, got_done}, exp_ref ? 16'h0002 : 16'h0001);
      check(16'(rq.size()), (op == nand_host_pkg::OP_PROGRAM || exp_ref) ? 16'h0000 : 16'(n));
   endtask
   // The first WR_TAKE opens word 0; each later one opens the next word
   always @(negedge CLK_SYS) if (WR_TAKE === 1'b1)
   begin
      if (take_seen) wi <= wi + 1;
      take_seen <= 1'b1;
   end
   always @(posedge CLK_SYS)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         miscompares++;
         finish_test();
      end
   end
   initial
   begin
      CLK_SYS = 1'b0;
      forever #4 CLK_SYS = ~CLK_SYS;
   end
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      {REQ_VALID, REQ_COL, REQ_ROW, REQ_WORDS, wi, cyc, miscompares, cmp_count} = '0;
      REQ_OP = nand_host_pkg::OP_STATUS;
      ext_busy_n = 1'b1;
      exp_ref = 1'b0;
      take_seen = 1'b0;
      RST_N = 1'b0;
      wdata = '{16'h1234, 16'hABCD, 16'h8001, 16'h00FF, 16'h0F0F, 16'h0000, 16'h0000, 16'h0000};
      repeat (20) @(negedge CLK_SYS);
      RST_N = 1'b1;
      run_op(nand_host_pkg::OP_ID, 8'h00, 18'h00000, 9'h002);
      check(rq[0], {8'h00, MAKER});
      check(rq[1], {8'h00, DEVICE});
      run_op(nand_host_pkg::OP_ID_EXT, 8'h00, 18'h00000, 9'h001);
      check(rq[0], 16'h0020);
      run_op(nand_host_pkg::OP_STATUS, 8'h00, 18'h00000, 9'h001);
      check(rq[0], 16'h0040);
      run_op(nand_host_pkg::OP_PROGRAM, 8'h00, 18'h00000, 9'h005);
      run_op(nand_host_pkg::OP_READ, 8'h00, 18'h00000, 9'h005);
      for (int i = 0; i < 5; i++) check(rq[i], wdata[i]);
      run_op(nand_host_pkg::OP_READ, 8'h02, 18'h00000, 9'h002);
      check(rq[0], 16'h8001);
      check(rq[1], 16'h00FF);
      run_op(nand_host_pkg::OP_PROGRAM, 8'hFF, 18'h3FFFF, 9'h001);
      run_op(nand_host_pkg::OP_READ, 8'hFF, 18'h3FFFF, 9'h001);
      check(rq[0], 16'h1234);
      run_op(nand_host_pkg::OP_PROGRAM, 8'h05, 18'h00020, 9'h002);
      run_op(nand_host_pkg::OP_ERASE, 8'h00, 18'h00003, 9'h000);
      run_op(nand_host_pkg::OP_READ, 8'h00, 18'h00000, 9'h001);
      check(rq[0], 16'hFFFF);
      run_op(nand_host_pkg::OP_READ, 8'h05, 18'h00020, 9'h002);
      check(rq[1], 16'hABCD);
      // Spare read comes after the programs: the pointer stays in the spare area until a main read
      run_op(nand_host_pkg::OP_READ_SPARE, 8'h00, 18'h00000, 9'h002);
      check(rq[0], 16'hFFFF);
      run_op(nand_host_pkg::OP_RESET, 8'h00, 18'h00000, 9'h000);
      run_op(nand_host_pkg::OP_STATUS, 8'h00, 18'h00000, 9'h001);
      check(rq[0], 16'h0040);
      // Other die holds the shared ready line low: only status and reset may go out
      ext_busy_n = 1'b0;
      exp_ref = 1'b1;
      run_op(nand_host_pkg::OP_ERASE, 8'h00, 18'h00040, 9'h000);
      exp_ref = 1'b0;
      run_op(nand_host_pkg::OP_STATUS, 8'h00, 18'h00000, 9'h001);
      check(rq[0], 16'h0040);
      ext_busy_n = 1'b1;
      finish_test();
   end
endmodule
